// file: port_host_model.sv
// Host model: SMBus/I2C controller that reads and writes the status bank.
// Assumes a pulled-up data line; it only ever pulls low or lets go.
`timescale 1ns/1ps
`default_nettype none
module port_host_model #(
  parameter logic [6:0] ADDR = 7'h00
) (
  // Clock
  input wire logic clk,
  // Bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // ***************
  // Bus primitives
  // ***************
  // Clock stands high between frames; data line released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Wait for a number of system clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Start, also a repeated start when the clock is low
  task automatic start_cond();
    tick(1);
    sda_low <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask
  // Stop, then the bus is left idle
  task automatic stop_cond();
    tick(1);
    sda_low <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask
  // One 80 ns bit: data set while low, sampled late in high phase
  task automatic xfer_bit(input logic b, output logic got);
    tick(1);
    sda_low <= ~b;
    tick(3);
    scl <= 1'b1;
    tick(3);
    #1 got = sda;
    tick(1);
    scl <= 1'b0;
  endtask
  // Byte out MSB first, returns device acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) xfer_bit(b[i], g);
    xfer_bit(1'b1, g);
    ack = ~g;
  endtask
  // Byte in MSB first, then acknowledge or not
  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, g);
      b[i] = g;
    end
    xfer_bit(nack, g);
  endtask
  // ***************
  // Register access
  // ***************
  // Pointer then data; a zero to the error bit asks for recovery
  task automatic write_reg(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start_cond();
    put_byte({ADDR, 1'b0}, a0);
    put_byte(p, a1);
    put_byte(d, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
  // Pointer write, repeated start, one byte read with no acknowledge
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start_cond();
    put_byte({ADDR, 1'b0}, a0);
    put_byte(p, a1);
    start_cond();
    put_byte({ADDR, 1'b1}, a2);
    get_byte(1'b1, d);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

// file: port_power_pkg.sv
// Constants, field layout and types for the port power status register bank.
// Assumes a single 100 MHz system clock and an SMBus/I2C host on two pins.
//
// Notes on behaviour
// - Active state keeps refreshing each port current
// - Current code 8-bit, port2 at 00h, port1 01h
// - Reading zeroed on sleep, switch off, discharge
// - Status bits 7,6 mirror fault lines live
// - Status bits 5,4 show constant-current limiting
// - Entering error sets port2 error state bit
// - Host writes zero; leave error if conditions gone
// - Other set flag bits hold port2 in error
// - Auto-recovery or power disable clears error state
// - Fault line two independent of error bit
// - Flags clear on read if gone, or with error
// - Discharge failure sets bit 6, alerts, errors
// - Power-up flag set, cleared by read or toggle
// - Power-up flag alerts nothing, survives sleep
// - Low output sets bit 4, alerts, errors
// - Overheat sets bit 3, both alerts, errors
// - Supply overvoltage sets bit 2, both alerts, errors
// - Back bias sets bit 1, alerts, errors
// - Overcurrent sets bit 0, alerts, errors
// - Unused bits ignore writes, read as zero
package port_power_pkg;
  // ***************
  // Register offsets
  // ***************
  localparam logic [7:0] REG_CUR2 = 8'h00;
  localparam logic [7:0] REG_CUR1 = 8'h01;
  localparam logic [7:0] REG_STAT = 8'h02;
  localparam logic [7:0] REG_ISR2 = 8'h03;
  // ***************
  // Field layout
  // ***************
  localparam int STAT_A1_BIT = 7;
  localparam int STAT_A2_BIT = 6;
  localparam int STAT_CC1_BIT = 5;
  localparam int STAT_CC2_BIT = 4;
  localparam int ERR_BIT = 7;
  localparam int PUP_BIT = 5;
  localparam logic [7:0] FAULT_MASK = 8'h5F;
  localparam logic [7:0] OTHER_MASK = 8'h7F;
  localparam logic [7:0] A1_MASK = 8'h0C;
  localparam logic [7:0] A2_MASK = 8'h5F;
  // ***************
  // Reset values
  // ***************
  localparam logic [7:0] CUR_RESET = 8'h00;
  localparam logic [7:0] ISR2_RESET = 8'h20;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [1:0] WARM_DONE = 2'h3;
  // ***************
  // Serial bit counting
  // ***************
  localparam logic [3:0] CNT_START = 4'hF;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h2C;
  typedef enum logic [2:0] {st_idle, st_addr, st_ptr, st_wr, st_rd} i2c_state_type;
endpackage

// file: port_power_status_registers.sv
// Status register bank of a dual port power switch, with its serial slave.
// Assumes analog comparators, port logic and pins are asynchronous; the
// current measurements arrive on the system clock with a strobe.
`timescale 1ns/1ps
`default_nettype none
module port_power_status_registers import port_power_pkg::*; #(
  parameter logic [6:0] BUS_ADDR = BUS_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial bus pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Open-drain fault lines
  input wire logic alert1_in,
  output logic alert1_out,
  output logic alert1_oe_n,
  input wire logic alert2_in,
  output logic alert2_out,
  output logic alert2_oe_n,
  input wire logic alert1_req,
  // Fault conditions
  input wire logic disch2,
  input wire logic keep2,
  input wire logic tsd,
  input wire logic ov,
  input wire logic back2,
  input wire logic ovlim2,
  // Port state
  input wire logic cc1,
  input wire logic cc2,
  input wire logic port2_power_enable,
  input wire logic auto_rec,
  input wire logic sleep,
  input wire logic sw1_on,
  input wire logic sw2_on,
  input wire logic dis1,
  input wire logic dis2,
  // Measurements
  input wire logic meas_stb,
  input wire logic [7:0] meas1,
  input wire logic [7:0] meas2,
  // Error state towards the switch
  output logic port2_error
);
  // ***************
  // Input synchronisers
  // ***************
  logic [19:0] raw;
  logic [19:0] s1;
  logic [19:0] s2;
  logic scl_s, sda_s, a1_s, a2_s, a1req_s;
  logic disch_s, keep_s, tsd_s, ov_s, back_s, ovlim_s;
  logic cc1_s, cc2_s, pwr_s, auto_s, sleep_s, sw1_s, sw2_s, dis1_s, dis2_s;
  assign raw = {scl, sda_in, alert1_in, alert2_in, alert1_req, disch2, keep2, tsd, ov, back2, ovlim2,
                cc1, cc2, port2_power_enable, auto_rec, sleep, sw1_on, sw2_on, dis1, dis2};
  // Two flops per asynchronous input
  for (genvar i = 0; i < 20; i++) begin : g_sync
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        s1[i] <= 1'b0;
        s2[i] <= 1'b0;
      end else begin
        s1[i] <= raw[i];
        s2[i] <= s1[i];
      end
    end
  end
  assign {scl_s, sda_s, a1_s, a2_s, a1req_s, disch_s, keep_s, tsd_s, ov_s, back_s, ovlim_s,
          cc1_s, cc2_s, pwr_s, auto_s, sleep_s, sw1_s, sw2_s, dis1_s, dis2_s} = s2;
  // ***************
  // Serial slave
  // ***************
  i2c_state_type st, next_st;
  logic [3:0] cnt, next_cnt; // Bit slot within a byte
  logic [7:0] sh, next_sh; // Received byte
  logic [7:0] tx, next_tx; // Byte being sent
  logic [7:0] ptr, next_ptr; // Register pointer
  logic drv, next_drv; // Pull data line low
  logic nack, next_nack; // Host acknowledge sampled
  logic scl_d, sda_d;
  logic rise, fall, start, stop;
  logic rd_stb, wr_stb, rd03;
  logic [7:0] rd_mux;
  logic [7:0] stat;
  logic [7:0] cur1, cur2, isr2;
  assign rise = scl_s && !scl_d;
  assign fall = !scl_s && scl_d;
  assign start = scl_s && scl_d && sda_d && !sda_s;
  assign stop = scl_s && scl_d && !sda_d && sda_s;
  // Port status view, unused low bits read zero
  always_comb begin
    stat = ZERO_BYTE;
    stat[STAT_A1_BIT] = !a1_s;
    stat[STAT_A2_BIT] = !a2_s;
    stat[STAT_CC1_BIT] = cc1_s;
    stat[STAT_CC2_BIT] = cc2_s;
  end
  // Read data by pointer; unmapped offsets read zero
  always_comb begin
    unique case (ptr)
      REG_CUR2: rd_mux = cur2;
      REG_CUR1: rd_mux = cur1;
      REG_STAT: rd_mux = stat;
      REG_ISR2: rd_mux = isr2;
      default: rd_mux = ZERO_BYTE;
    endcase
  end
  // Bus sequencing: bits sampled on rise, driven after fall
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_sh = sh;
    next_tx = tx;
    next_drv = drv;
    next_ptr = ptr;
    next_nack = nack;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    if (start) begin
      // Start or repeated start; the start's own fall wraps the count
      next_st = st_addr;
      next_cnt = CNT_START;
      next_drv = 1'b0;
    end else if (stop) begin
      next_st = st_idle;
      next_drv = 1'b0;
    end else if (st != st_idle && rise) begin
      // Ninth clock carries the host acknowledge
      if (cnt == ACK_SLOT) begin
        next_nack = sda_s;
      end else begin
        next_sh = {sh[6:0], sda_s};
      end
    end else if (st != st_idle && fall) begin
      if (cnt == BYTE_LAST) begin
        // Byte complete: acknowledge or release
        next_cnt = ACK_SLOT;
        if (st == st_rd) begin
          next_drv = 1'b0;
        end else if (st == st_addr && sh[7:1] != BUS_ADDR) begin
          next_st = st_idle;
        end else begin
          next_drv = 1'b1;
        end
      end else if (cnt == ACK_SLOT) begin
        // Acknowledge slot over: act on the byte
        next_cnt = 4'h0;
        next_drv = 1'b0;
        unique case (st)
          st_addr: begin
            if (sh[0]) begin
              next_st = st_rd;
              rd_stb = 1'b1;
            end else begin
              next_st = st_ptr;
            end
          end
          st_ptr: begin
            next_ptr = sh;
            next_st = st_wr;
          end
          st_wr: begin
            wr_stb = 1'b1;
            next_ptr = ptr + 8'h01;
          end
          st_rd: begin
            if (nack) begin
              next_st = st_idle;
            end else begin
              rd_stb = 1'b1;
            end
          end
          st_idle: begin
          end
        endcase
        // Load next byte to send and advance the pointer
        if (rd_stb) begin
          next_tx = rd_mux;
          next_ptr = ptr + 8'h01;
          next_drv = !rd_mux[7];
        end
      end else begin
        next_cnt = cnt + 4'h1;
        if (st == st_rd) begin
          next_tx = {tx[6:0], 1'b0};
          next_drv = !tx[6];
        end
      end
    end
  end
  assign rd03 = rd_stb && ptr == REG_ISR2;
  // Serial slave state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= st_idle;
      cnt <= 4'h0;
      sh <= ZERO_BYTE;
      tx <= ZERO_BYTE;
      ptr <= ZERO_BYTE;
      drv <= 1'b0;
      nack <= 1'b0;
      scl_d <= 1'b0;
      sda_d <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      sh <= next_sh;
      tx <= next_tx;
      ptr <= next_ptr;
      drv <= next_drv;
      nack <= next_nack;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe_n = !drv;
  // ***************
  // Register bank
  // ***************
  logic [7:0] next_cur1, next_cur2, next_isr2;
  logic next_a1, next_a2, a1_drv, a2_drv, pwr_d;
  logic [1:0] warm, next_warm; // Edges since reset, saturating
  logic [7:0] cond8, other, clr;
  logic any_cond, host_clr, auto_clr, err_clr;
  // Current readings, fault flags, error state and fault lines
  always_comb begin
    cond8 = {1'b0, disch_s, 1'b0, keep_s, tsd_s, ov_s, back_s, ovlim_s};
    any_cond = |cond8;
    other = isr2 & OTHER_MASK;
    host_clr = wr_stb && ptr == REG_ISR2 && !sh[ERR_BIT] && other == ZERO_BYTE && !any_cond;
    auto_clr = auto_s && !any_cond;
    err_clr = host_clr || auto_clr || !pwr_s;
    clr = ZERO_BYTE;
    if (rd03) begin
      clr = ~cond8;
    end
    if (err_clr && isr2[ERR_BIT]) begin
      clr = clr | FAULT_MASK;
    end
    // Set wins over any clear
    next_isr2 = (cond8 | (isr2 & ~clr)) & FAULT_MASK;
    next_isr2[ERR_BIT] = any_cond || (isr2[ERR_BIT] && !err_clr);
    next_warm = (warm == WARM_DONE) ? warm : warm + 2'h1; // Enable edges ignored until sync pipe is real
    next_isr2[PUP_BIT] = isr2[PUP_BIT] && !(rd03 || (pwr_s != pwr_d && warm == WARM_DONE));
    // Fault lines follow flags, line 1 also the port-1 request, never the error bit
    next_a2 = |(next_isr2 & A2_MASK);
    next_a1 = |(next_isr2 & A1_MASK) || a1req_s;
    // Readings refresh in Active, zero when off or discharged
    next_cur2 = cur2;
    next_cur1 = cur1;
    if (meas_stb) begin
      next_cur2 = meas2;
      next_cur1 = meas1;
    end
    if (sleep_s || !sw2_s || dis2_s) begin
      next_cur2 = CUR_RESET;
    end
    if (sleep_s || !sw1_s || dis1_s) begin
      next_cur1 = CUR_RESET;
    end
  end
  // Register bank state; power-up flag set by reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur1 <= CUR_RESET;
      cur2 <= CUR_RESET;
      isr2 <= ISR2_RESET;
      a1_drv <= 1'b0;
      a2_drv <= 1'b0;
      pwr_d <= 1'b0;
      warm <= 2'h0;
    end else begin
      cur1 <= next_cur1;
      cur2 <= next_cur2;
      isr2 <= next_isr2;
      a1_drv <= next_a1;
      a2_drv <= next_a2;
      pwr_d <= pwr_s;
      warm <= next_warm;
    end
  end
  assign alert1_out = 1'b0;
  assign alert2_out = 1'b0;
  assign alert1_oe_n = !a1_drv;
  assign alert2_oe_n = !a2_drv;
  assign port2_error = isr2[ERR_BIT];
  // ***************
  // Assertions
  // ***************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  property p_meas;
    meas_stb && !sleep_s && sw2_s && !dis2_s |=> cur2 == $past(meas2);
  endproperty
  a_meas: assert property (p_meas) else $error("port2 reading not refreshed");
  property p_zero;
    sleep_s |=> cur1 == CUR_RESET && cur2 == CUR_RESET;
  endproperty
  a_zero: assert property (p_zero) else $error("reading not zeroed in sleep");
  property p_err_set;
    any_cond |=> port2_error && (isr2 & FAULT_MASK) != ZERO_BYTE;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error state not entered");
  property p_host_clr;
    host_clr |=> !port2_error;
  endproperty
  a_host_clr: assert property (p_host_clr) else $error("host recovery failed");
  property p_hold;
    port2_error && other != ZERO_BYTE && pwr_s && !auto_s |=> port2_error;
  endproperty
  a_hold: assert property (p_hold) else $error("error left with flags set");
  property p_pwr_off;
    !pwr_s && !any_cond |=> !port2_error;
  endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("error kept with power off");
  property p_cor;
    rd03 && !any_cond |=> (isr2 & FAULT_MASK) == ZERO_BYTE && !isr2[PUP_BIT];
  endproperty
  a_cor: assert property (p_cor) else $error("flags not cleared on read");
  property p_both_lines;
    tsd_s || ov_s |=> !alert1_oe_n && !alert2_oe_n;
  endproperty
  a_both_lines: assert property (p_both_lines) else $error("fault lines not asserted");
  property p_line2;
    alert2_oe_n == ((isr2 & A2_MASK) == ZERO_BYTE);
  endproperty
  a_line2: assert property (p_line2) else $error("fault line two mismatch");
  c_read_isr: cover property (rd03 ##1 !isr2[PUP_BIT]);
  c_recover: cover property (port2_error ##[1:200] !port2_error);
  c_nack: cover property (st == st_rd && fall && cnt == ACK_SLOT && nack);
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the port power status register bank.
// Assumes the host model as the only bus master and pull-ups on all lines.
`timescale 1ns/1ps
`default_nettype none
module tb import port_power_pkg::*;;
  // ***************
  // Stimulus and wires
  // ***************
  typedef struct packed {logic [5:0] cond; logic [7:0] flags; logic a1_oe_n;} fault_row_type;
  localparam fault_row_type rows [6] = '{'{6'h20, 8'h40, 1'b1}, '{6'h10, 8'h10, 1'b1},
    '{6'h08, 8'h08, 1'b0}, '{6'h04, 8'h04, 1'b0}, '{6'h02, 8'h02, 1'b1}, '{6'h01, 8'h01, 1'b1}};
  // Port controls {sleep, sw1, sw2, dis1, dis2}
  localparam logic [4:0] ctl_rows [7] = '{5'h0C, 5'h1C, 5'h04, 5'h08, 5'h0E, 5'h0D, 5'h0C};
  logic clk = 1'b0, resetn = 1'b0, alert1_req = 1'b0, cc1 = 1'b0, cc2 = 1'b0;
  logic port2_power_enable = 1'b1, auto_rec = 1'b0, meas_stb = 1'b0;
  logic [5:0] cond = 6'h00;
  logic [4:0] ctl = 5'h0C;
  logic [7:0] meas1 = 8'h00, meas2 = 8'h00, e1, e2;
  wire logic scl, sda_low, sda, sda_oe_n, alert1_oe_n, alert2_oe_n, port2_error;
  wire logic disch2, keep2, tsd, ov, back2, ovlim2, sleep, sw1_on, sw2_on, dis1, dis2;
  int error_cnt = 0, n_tests = 0;
  assign {disch2, keep2, tsd, ov, back2, ovlim2} = cond;
  assign {sleep, sw1_on, sw2_on, dis1, dis2} = ctl;
  // Pulled-up lines: low when any party pulls
  assign sda = ~sda_low & sda_oe_n;
  always #5 clk = ~clk;
  // ***************
  // Instances
  // ***************
  port_host_model #(.ADDR(BUS_ADDR_DEFAULT)) host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  port_power_status_registers DUT (.clk(clk), .resetn(resetn), .scl(scl), .sda_in(sda), .sda_out(),
    .sda_oe_n(sda_oe_n), .alert1_in(alert1_oe_n), .alert1_out(), .alert1_oe_n(alert1_oe_n),
    .alert2_in(alert2_oe_n), .alert2_out(), .alert2_oe_n(alert2_oe_n), .alert1_req(alert1_req),
    .disch2(disch2), .keep2(keep2), .tsd(tsd), .ov(ov), .back2(back2), .ovlim2(ovlim2), .cc1(cc1),
    .cc2(cc2), .port2_power_enable(port2_power_enable), .auto_rec(auto_rec), .sleep(sleep), .sw1_on(sw1_on), .sw2_on(sw2_on),
    .dis1(dis1), .dis2(dis2), .meas_stb(meas_stb), .meas1(meas1), .meas2(meas2), .port2_error(port2_error));
  // ***************
  // Helpers
  // ***************
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  // Bus write that must be acknowledged
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    host.write_reg(p, d, ok);
    chk({7'h00, ok}, 8'h01);
  endtask
  // Bus read compared with an expected byte
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    logic ok;
    logic [7:0] d;
    host.read_reg(p, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, e);
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog against a hung bus
  initial begin
    wait_clk(60000);
    error_cnt++;
    wrap_up();
  end
  // ***************
  // Main sequence
  // ***************
  initial begin
    wait_clk(20);
    resetn <= 1'b1;
    wait_clk(6);
    // Power-up flag alone, alerts idle, port-2 reading zero
    rd(REG_ISR2, 8'h20);
    chk({6'h00, alert1_oe_n, alert2_oe_n}, 8'h03);
    rd(REG_ISR2, 8'h00);
    rd(REG_CUR2, 8'h00);
    rd(REG_STAT, 8'h00);
    // Each fault condition through set, hold, recovery
    for (int k = 0; k < 6; k++) begin
      cond <= rows[k].cond;
      wait_clk(8);
      chk({5'h00, alert1_oe_n, alert2_oe_n, port2_error}, {5'h00, rows[k].a1_oe_n, 2'b01});
      rd(REG_STAT, {~rows[k].a1_oe_n, 7'h40});
      wr(REG_ISR2, 8'h00);
      rd(REG_ISR2, 8'h80 | rows[k].flags);
      cond <= 6'h00;
      wait_clk(8);
      wr(REG_ISR2, 8'h00);
      rd(REG_ISR2, 8'h80 | rows[k].flags);
      wr(REG_ISR2, 8'h00);
      rd(REG_ISR2, 8'h00);
      chk({5'h00, alert1_oe_n, alert2_oe_n, port2_error}, 8'h06);
    end
    // Readings refreshed, forced zero by sleep, switch off, discharge
    for (int j = 0; j < 7; j++) begin
      ctl <= ctl_rows[j];
      meas1 <= 8'hFF - 8'(j);
      meas2 <= 8'h10 + 8'(j);
      e1 = (ctl_rows[j][4] | ~ctl_rows[j][3] | ctl_rows[j][1]) ? 8'h00 : 8'hFF - 8'(j);
      e2 = (ctl_rows[j][4] | ~ctl_rows[j][2] | ctl_rows[j][0]) ? 8'h00 : 8'h10 + 8'(j);
      wait_clk(6);
      meas_stb <= 1'b1;
      wait_clk(1);
      meas_stb <= 1'b0;
      wait_clk(2);
      rd(REG_CUR2, e2);
      rd(REG_CUR1, e1);
    end
    // Constant-current bits
    for (int c = 0; c < 4; c++) begin
      {cc1, cc2} <= 2'(c);
      wait_clk(6);
      rd(REG_STAT, {2'b00, 2'(c), 4'h0});
    end
    {cc1, cc2} <= 2'b00;
    // Port-1 request drives line 1 with no error on port 2
    alert1_req <= 1'b1;
    wait_clk(8);
    chk({6'h00, alert1_oe_n, port2_error}, 8'h00);
    rd(REG_STAT, 8'h80);
    alert1_req <= 1'b0;
    // Auto-recovery clears error and flags
    cond <= 6'h08;
    wait_clk(8);
    cond <= 6'h00;
    auto_rec <= 1'b1;
    wait_clk(8);
    chk({7'h00, port2_error}, 8'h00);
    rd(REG_ISR2, 8'h00);
    auto_rec <= 1'b0;
    // Read-only, unmapped and reserved writes ignored
    wr(REG_CUR2, 8'hFF);
    wr(REG_STAT, 8'hFF);
    wr(8'h05, 8'hFF);
    wr(REG_ISR2, 8'hFF);
    rd(REG_CUR2, 8'h16);
    rd(REG_STAT, 8'h00);
    rd(8'h05, 8'h00);
    rd(REG_ISR2, 8'h00);
    // Second reset, power enable toggle clears power-up flag
    resetn <= 1'b0;
    wait_clk(3);
    resetn <= 1'b1;
    wait_clk(6);
    // Power-up flag kept through sleep, then a fresh reset for the toggle
    ctl <= 5'h1C;
    wait_clk(8);
    ctl <= 5'h0C;
    wait_clk(8);
    rd(REG_ISR2, 8'h20);
    resetn <= 1'b0;
    wait_clk(3);
    resetn <= 1'b1;
    wait_clk(6);
    port2_power_enable <= 1'b0;
    wait_clk(8);
    port2_power_enable <= 1'b1;
    wait_clk(8);
    rd(REG_ISR2, 8'h00);
    rd(REG_CUR1, 8'h00);
    // Power disable clears error state
    cond <= 6'h02;
    wait_clk(8);
    cond <= 6'h00;
    port2_power_enable <= 1'b0;
    wait_clk(8);
    chk({7'h00, port2_error}, 8'h00);
    rd(REG_ISR2, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
